// ### hw/lpw_top.sv
// Low-power mode entry and wake-up flag controller with Wishbone registers
// What this block does
// - Writing one to config bit 7 enters sleep mode; not readable.
// - Writing one to config bit 6 enters suspend mode; not readable.
// - Writing one to config bit 5 clears all wake-up flags at once.
// - Bit 4 is a read-only flag set by a reset-pin falling edge.
// - Bit 3 writes osc-fail wake enable, reads osc-fail flag.
// - Bit 2 writes alarm wake enable, reads alarm flag.
// - Bit 1 writes port-match wake enable, reads port-match flag.
// - Bit 0 writes comparator rising-edge enable, reads its flag.
// - Any flag set blocks suspend and sleep entry, keeps low-power oscillator on.
// - Writing one to power control bit 1 enters stop mode.
// - Writing one to power control bit 0 enters idle mode.
// - Power control bits 7 to 2 are six read/write general flags.
// - Config register at 0xb5 on page 0, power control 0x87 all pages.
// - Flags read zero for two clocks after suspend wake-up.
// - Flags set on every event, enabled or not, also after wake-up.
// - A reset-pin falling edge always ends sleep mode.
// - Suspend gates the system clock until an enabled source fires or a reset-pin falling edge comes.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module lpw_top
    import lpw_pkg::*;
#(
    parameter int AW = 10
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Wake-up event sources
    input wire logic rtc_osc_fail_i,
    input wire logic rtc_alarm_i,
    input wire logic port_match_i,
    input wire logic comparator_i,
    input wire logic reset_pin_n_i,
    // Power state outputs
    output logic idle_req_o,
    output logic stop_req_o,
    output logic sys_clk_gate_o,
    output logic regulator_off_o,
    output logic lp_osc_en_o,
    output logic wake_o
);
    import lpw_pkg::*;

    lpw_reg_if rif();

    logic [LPW_NUM_SRC-1:0] ev_level;
    logic [LPW_NUM_SRC-1:0] ev_pulse;
    lpw_mode_t mode_reg, mode_next;
    logic [4:0] flag_reg, flag_next;
    logic [3:0] en_reg, en_next;
    logic [5:0] gf_reg, gf_next;
    logic [3:0] page_reg, page_next;
    logic [1:0] mask_reg, mask_next;
    logic idle_reg, idle_next;
    logic stop_reg, stop_next;
    logic wake_reg, wake_next;
    logic pwr_wr, cfg_wr, page_wr;
    logic any_flag, wake_ev, lp_ok;
    logic [4:0] flag_vis;

    // Bus front end
    lpw_wb_slave #(.AW(AW)) u_bus (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .rif(rif)
    );

    // Source order matches the flag bit order of the config register
    assign ev_level = {reset_pin_n_i, rtc_osc_fail_i, rtc_alarm_i, port_match_i,
                       comparator_i};

    lpw_event_detect #(.N(LPW_NUM_SRC), .FALLING(LPW_SRC_FALLING)) u_events (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .level_i(ev_level),
        .pulse_o(ev_pulse)
    );

    // Address decode; the config register only answers on its own page
    always_comb begin
        pwr_wr = rif.wr_stb && (rif.idx == LPW_PWR_CTRL_IDX);
        cfg_wr = rif.wr_stb && (rif.idx == LPW_WAKE_CFG_IDX)
                 && (page_reg == LPW_WAKE_PAGE);
        page_wr = rif.wr_stb && (rif.idx == LPW_PAGE_IDX);
    end

    // Wake conditions
    always_comb begin
        any_flag = |flag_reg;
        wake_ev = (|(ev_pulse[LPW_EN_MSB:0] & en_reg))
                  | ev_pulse[LPW_RESET_PIN_WAKE_FLAG_BIT];
        lp_ok = cfg_wr && !any_flag && (mode_reg == LPW_ACTIVE);
    end

    // Flags, enables, mode and strobes
    always_comb begin
        flag_next = flag_reg;
        en_next = en_reg;
        gf_next = gf_reg;
        page_next = page_reg;
        mode_next = mode_reg;
        mask_next = (mask_reg != 2'h0) ? mask_reg - 2'h1 : mask_reg;
        idle_next = 1'b0;
        stop_next = 1'b0;
        wake_next = 1'b0;
        if (cfg_wr && rif.wdata[LPW_CLEAR_BIT]) begin
            flag_next = LPW_FLAGS_RST;
        end
        // Set after clear so an event in the clearing cycle survives
        flag_next = flag_next | ev_pulse;
        if (cfg_wr) begin
            en_next = rif.wdata[LPW_EN_MSB:0];
        end
        if (pwr_wr) begin
            gf_next = rif.wdata[7:LPW_GF_LSB];
            stop_next = rif.wdata[LPW_STOP_BIT];
            idle_next = rif.wdata[LPW_IDLE_BIT];
        end
        if (page_wr) begin
            page_next = rif.wdata[3:0];
        end
        case (mode_reg)
            LPW_ACTIVE: begin
                if (lp_ok && rif.wdata[LPW_SLEEP_BIT]) begin
                    mode_next = LPW_SLEEP;
                end else if (lp_ok && rif.wdata[LPW_SUSPEND_BIT]) begin
                    mode_next = LPW_SUSPEND;
                end
            end
            LPW_SUSPEND: begin
                if (wake_ev) begin
                    mode_next = LPW_ACTIVE;
                    mask_next = LPW_WAKE_MASK_CYC;
                    wake_next = 1'b1;
                    en_next = LPW_EN_RST;
                end
            end
            LPW_SLEEP: begin
                if (wake_ev) begin
                    mode_next = LPW_ACTIVE;
                    wake_next = 1'b1;
                    en_next = LPW_EN_RST;
                end
            end
            default: begin
                mode_next = LPW_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_reg <= LPW_ACTIVE;
            flag_reg <= LPW_FLAGS_RST;
            en_reg <= LPW_EN_RST;
            gf_reg <= LPW_GF_RST;
            page_reg <= LPW_PAGE_RST;
            mask_reg <= 2'h0;
            idle_reg <= 1'b0;
            stop_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            flag_reg <= flag_next;
            en_reg <= en_next;
            gf_reg <= gf_next;
            page_reg <= page_next;
            mask_reg <= mask_next;
            idle_reg <= idle_next;
            stop_reg <= stop_next;
            wake_reg <= wake_next;
        end
    end

    // Read mux; enables are not readable, so read-modify-write loses them
    always_comb begin
        flag_vis = (mask_reg != 2'h0) ? 5'h00 : flag_reg;
        if (rif.idx == LPW_WAKE_CFG_IDX && page_reg == LPW_WAKE_PAGE) begin
            rif.rdata = {3'b000, flag_vis};
        end else if (rif.idx == LPW_PWR_CTRL_IDX) begin
            rif.rdata = {gf_reg, 2'b00};
        end else if (rif.idx == LPW_PAGE_IDX) begin
            rif.rdata = {4'h0, page_reg};
        end else begin
            rif.rdata = 8'h00;
        end
    end

    // Power state outputs
    assign idle_req_o = idle_reg;
    assign stop_req_o = stop_reg;
    assign wake_o = wake_reg;
    assign sys_clk_gate_o = (mode_reg == LPW_SUSPEND);
    assign regulator_off_o = (mode_reg == LPW_SLEEP);
    assign lp_osc_en_o = any_flag || (mode_reg == LPW_ACTIVE);

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    flag_rstpin_a: assert property (ev_pulse[4] |=> flag_reg[4])
        else $error("reset pin edge did not set its flag");
    flag_oscfail_a: assert property (ev_pulse[3] |=> flag_reg[3])
        else $error("osc fail event did not set its flag");
    flag_alarm_a: assert property (ev_pulse[2] |=> flag_reg[2])
        else $error("alarm event did not set its flag");
    flag_match_a: assert property (ev_pulse[1] |=> flag_reg[1])
        else $error("port match event did not set its flag");
    flag_cmp_a: assert property (ev_pulse[0] |=> flag_reg[0])
        else $error("comparator edge did not set its flag");
    flag_clear_a: assert property (cfg_wr && rif.wdata[5] && ev_pulse == 5'h00
        |=> flag_reg == 5'h00)
        else $error("clear write left a flag set");
    entry_block_a: assert property (mode_reg == LPW_ACTIVE && any_flag
        |=> mode_reg == LPW_ACTIVE)
        else $error("low-power entry taken with a flag set");
    sleep_entry_a: assert property (lp_ok && rif.wdata[7]
        |=> mode_reg == LPW_SLEEP && regulator_off_o)
        else $error("sleep write did not enter sleep");
    suspend_entry_a: assert property (lp_ok && !rif.wdata[7] && rif.wdata[6]
        |=> sys_clk_gate_o)
        else $error("suspend write did not gate the clock");
    wake_mask_a: assert property (mode_reg == LPW_SUSPEND && wake_ev
        |=> flag_vis == 5'h00 [*2])
        else $error("flags visible too early after suspend wake-up");
    rstpin_wake_a: assert property (mode_reg == LPW_SLEEP && ev_pulse[4]
        |=> mode_reg == LPW_ACTIVE && en_reg == 4'h0)
        else $error("reset pin edge did not end sleep");
    stay_low_a: assert property (mode_reg != LPW_ACTIVE && !wake_ev
        |=> $stable(mode_reg))
        else $error("low-power mode left without an enabled event");
    stop_pulse_a: assert property (pwr_wr && rif.wdata[1]
        |=> stop_req_o ##1 !stop_req_o)
        else $error("stop strobe not a single cycle");
    idle_pulse_a: assert property (pwr_wr && rif.wdata[0]
        |=> idle_req_o ##1 !idle_req_o)
        else $error("idle strobe not a single cycle");
    gf_store_a: assert property (pwr_wr |=> gf_reg == $past(rif.wdata[7:2]))
        else $error("general flags did not store the write");

    sleep_cycle_c: cover property (mode_reg == LPW_SLEEP ##[1:20] wake_o);
    suspend_cycle_c: cover property (mode_reg == LPW_SUSPEND ##[1:20] wake_o);
    blocked_entry_c: cover property (cfg_wr && any_flag && rif.wdata[6]);
    clear_race_c: cover property (cfg_wr && rif.wdata[5] && ev_pulse != 5'h00);
endmodule
`default_nettype wire

// ### hw/lpw_pkg.sv
// Constants, register map and mode type for the low-power wake-up controller
package lpw_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] LPW_PWR_CTRL_IDX = 8'h87;
    localparam logic [7:0] LPW_WAKE_CFG_IDX = 8'hb5;
    localparam logic [7:0] LPW_PAGE_IDX = 8'ha0;
    localparam logic [3:0] LPW_WAKE_PAGE = 4'h0;
    // Wake-up configuration register fields
    localparam int LPW_SLEEP_BIT = 7;
    localparam int LPW_SUSPEND_BIT = 6;
    localparam int LPW_CLEAR_BIT = 5;
    localparam int LPW_RESET_PIN_WAKE_FLAG_BIT = 4;
    localparam int LPW_EN_MSB = 3;
    // Power control register fields
    localparam int LPW_GF_LSB = 2;
    localparam int LPW_STOP_BIT = 1;
    localparam int LPW_IDLE_BIT = 0;
    // Reset values
    localparam logic [5:0] LPW_GF_RST = 6'h00;
    localparam logic [4:0] LPW_FLAGS_RST = 5'h00;
    localparam logic [3:0] LPW_EN_RST = 4'h0;
    localparam logic [3:0] LPW_PAGE_RST = 4'h0;
    // Event sources: 0 comparator, 1 port match, 2 alarm, 3 osc fail, 4 reset pin
    localparam int LPW_NUM_SRC = 5;
    localparam logic [4:0] LPW_SRC_FALLING = 5'h10;
    // Clocks during which flags read as zero after a suspend wake-up
    localparam logic [1:0] LPW_WAKE_MASK_CYC = 2'h2;
    typedef enum logic [1:0] {
        LPW_ACTIVE = 2'b00,
        LPW_SUSPEND = 2'b01,
        LPW_SLEEP = 2'b10
    } lpw_mode_t;
endpackage

// ### hw/lpw_reg_if.sv
// Internal register access path between bus slave and controller core
`timescale 1ns/1ps
`default_nettype none
interface lpw_reg_if;
    logic wr_stb;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport bus (output wr_stb, output idx, output wdata, input rdata);
    modport core (input wr_stb, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ### hw/lpw_event_detect.sv
// Per-source edge detector turning event lines into one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module lpw_event_detect #(
    parameter int N = 5,
    parameter logic [N-1:0] FALLING = '0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Event lines and pulses
    input wire logic [N-1:0] level_i,
    output logic [N-1:0] pulse_o
);
    logic [N-1:0] prev_reg;
    logic [N-1:0] prev_next;

    // Previous level; resets to idle level so release gives no false edge
    always_comb begin
        prev_next = level_i;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_reg <= FALLING;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // Rising edge, or falling edge where the polarity bit is set
    for (genvar i = 0; i < N; i++) begin : g_edge
        assign pulse_o[i] = FALLING[i] ? (prev_reg[i] & ~level_i[i])
                                       : (~prev_reg[i] & level_i[i]);

        pulse_short_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
            pulse_o[i] |=> !pulse_o[i])
            else $error("event pulse lasted more than one cycle");
    end
endmodule
`default_nettype wire

// ### hw/lpw_wb_slave.sv
// Classic Wishbone slave feeding byte-wide register strobes
`timescale 1ns/1ps
`default_nettype none
module lpw_wb_slave #(
    parameter int AW = 10
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Register path
    lpw_reg_if.bus rif
);
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic req;

    // One ack per request; the gap after ack blocks a repeated strobe
    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~ack_reg;
        ack_next = req;
        dat_next = req ? {24'h000000, rif.rdata} : dat_reg;
        rif.wr_stb = req & wb_we_i & wb_sel_i[0];
        rif.idx = wb_adr_i[9:2];
        rif.wdata = wb_dat_i[7:0];
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    ack_one_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        wb_cyc_i && wb_stb_i && !ack_reg |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the low-power wake-up controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lpw_pkg::*;
    localparam logic [9:0] A_PWR = {LPW_PWR_CTRL_IDX, 2'b00};
    localparam logic [9:0] A_CFG = {LPW_WAKE_CFG_IDX, 2'b00};
    localparam logic [9:0] A_PAGE = {LPW_PAGE_IDX, 2'b00};
    localparam logic [9:0] A_NONE = 10'h3fc;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [9:0] wb_adr = 10'h000;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack;
    logic [3:0] src = 4'h0;
    logic rst_pin_n = 1'b1;
    logic idle_req, stop_req, clk_gate, reg_off, lp_osc, wake;
    logic idle_seen, stop_seen;
    logic [31:0] rq;
    int n_mismatch = 0;
    int n_checks = 0;

    lpw_top #(.AW(10)) dut_u (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat_i), .wb_sel_i(4'h1), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack),
        .rtc_osc_fail_i(src[3]), .rtc_alarm_i(src[2]), .port_match_i(src[1]),
        .comparator_i(src[0]), .reset_pin_n_i(rst_pin_n),
        .idle_req_o(idle_req), .stop_req_o(stop_req), .sys_clk_gate_o(clk_gate),
        .regulator_off_o(reg_off), .lp_osc_en_o(lp_osc), .wake_o(wake)
    );

    // 40 MHz system clock
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic cycle; waits for ack with a bound, takes data at the ack edge
    task automatic xfer(input logic we, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rq = wb_dat_o;
        idle_seen = idle_req;
        stop_seen = stop_req;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(rq, {24'h0, exp});
    endtask

    // One-cycle event on a source, then one cycle for the flag to land
    task automatic pulse(input int i);
        @(posedge core_clk_i);
        src[i] <= 1'b1;
        @(posedge core_clk_i);
        src[i] <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic pin_fall();
        @(posedge core_clk_i);
        rst_pin_n <= 1'b0;
        @(posedge core_clk_i);
        rst_pin_n <= 1'b1;
    endtask

    // Counts wake pulse cycles over a bounded window
    task automatic wait_wake(output int hi);
        hi = 0;
        repeat (12) begin
            @(posedge core_clk_i);
            if (wake === 1'b1) hi++;
        end
    endtask

    task automatic t_reset();
        chk({idle_req, stop_req, clk_gate, reg_off, wake}, 32'h0);
        chk(lp_osc, 1'b1);
        rd(A_PWR, 8'h00);
        rd(A_CFG, 8'h00);
        rd(A_NONE, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_pwr();
        wr(A_PWR, 8'hff);
        chk({idle_seen, stop_seen}, 2'b11);
        @(posedge core_clk_i);
        chk({idle_req, stop_req}, 2'b00);
        rd(A_PWR, 8'hfc);
        wr(A_PWR, 8'ha9);
        chk({idle_seen, stop_seen}, 2'b10);
        rd(A_PWR, 8'ha8);
        wr(A_PWR, 8'h56);
        chk({idle_seen, stop_seen}, 2'b01);
        rd(A_PWR, 8'h54);
        $display("test power control done");
    endtask

    task automatic t_flags();
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            rd(A_CFG, 8'((1 << (i + 1)) - 1));
        end
        wr(A_CFG, 8'h00);
        rd(A_CFG, 8'h0f);
        pin_fall();
        @(posedge core_clk_i);
        rd(A_CFG, 8'h1f);
        // Page other than zero hides the configuration register
        wr(A_PAGE, 8'h01);
        rd(A_PAGE, 8'h01);
        rd(A_CFG, 8'h00);
        wr(A_CFG, 8'h20);
        wr(A_PAGE, 8'h00);
        rd(A_CFG, 8'h1f);
        wr(A_CFG, 8'h20);
        rd(A_CFG, 8'h00);
        $display("test flags done");
    endtask

    task automatic t_modes();
        int hi;
        // A set flag blocks both entries
        pulse(2);
        wr(A_CFG, 8'h8f);
        @(posedge core_clk_i);
        chk({reg_off, clk_gate, lp_osc}, 3'b001);
        wr(A_CFG, 8'h4f);
        @(posedge core_clk_i);
        chk({reg_off, clk_gate, lp_osc}, 3'b001);
        wr(A_CFG, 8'h20);
        // Suspend with only port match enabled, set in the entry write
        wr(A_CFG, 8'h42);
        @(posedge core_clk_i);
        chk({clk_gate, lp_osc}, 2'b10);
        pulse(0);
        chk({clk_gate, lp_osc, wake}, 3'b110);
        // Wake pulse follows the edge at once, so watch from the rise itself
        @(posedge core_clk_i);
        src[1] <= 1'b1;
        wait_wake(hi);
        src[1] <= 1'b0;
        chk(hi, 1);
        chk(clk_gate, 1'b0);
        rd(A_CFG, 8'h03);
        wr(A_CFG, 8'h20);
        // Sleep with no enables: only the reset pin ends it
        wr(A_CFG, 8'h80);
        @(posedge core_clk_i);
        chk({reg_off, lp_osc}, 2'b10);
        pulse(2);
        chk({reg_off, wake}, 2'b10);
        pin_fall();
        wait_wake(hi);
        chk(hi, 1);
        chk(reg_off, 1'b0);
        rd(A_CFG, 8'h14);
        wr(A_CFG, 8'h20);
        $display("test modes done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(posedge core_clk_i);
        t_reset();
        t_pwr();
        t_flags();
        t_modes();
        stop_test();
    end

    // Tests need well under a thousand cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
